// ### hdl/mswc_pkg.sv
package mswc_pkg;

	// Sleep settings
	localparam logic [3:0] SLEEP_NONE      = 4'h0;
	localparam logic [3:0] SLEEP_PIN       = 4'h1;
	localparam logic [3:0] SLEEP_SERIAL    = 4'h2;
	localparam logic [3:0] SLEEP_CYC_FIRST = 4'h3;
	localparam logic [3:0] SLEEP_CYC_LAST  = 4'h8;

	// Reset values and the timeout minimum
	localparam logic [3:0]  SLEEP_RESET   = 4'h0;
	localparam logic        PWAKE_RESET   = 1'h0;
	localparam logic [15:0] TIMEOUT_RESET = 16'h0064;
	localparam logic [15:0] TIMEOUT_MIN   = 16'h0010;
	localparam logic [7:0]  INIT_LEN_RESET  = 8'h01;
	localparam logic [15:0] HOLDOFF_RESET   = 16'hFFFF;

	// Register byte offsets
	localparam logic [7:0] REG_SLEEP_CTRL = 8'h00;
	localparam logic [7:0] REG_TIMEOUT    = 8'h04;
	localparam logic [7:0] REG_INIT_CFG   = 8'h08;
	localparam logic [7:0] REG_STATUS     = 8'h0C;

	// Field positions
	localparam int SLEEP_LSB = 0;
	localparam int PWAKE_BIT = 4;
	localparam int ILEN_LSB  = 0;
	localparam int HOLD_LSB  = 16;

	// Timing
	localparam int CLK_HZ      = 100_000_000;
	localparam int TICK_MS     = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int DETECT_US   = 35_000;
	localparam int DETECT_CYCLES = (DETECT_US * (CLK_HZ / 1_000_000));

	typedef enum logic [1:0] {
		MSWC_ACTIVE,
		MSWC_ASLEEP,
		MSWC_LISTEN,
		MSWC_SYNC
	} mswc_state_e;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} mswc_wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} mswc_wb_rsp_s;

endpackage

// ### hdl/mswc_top.sv
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module mswc_top #(
	parameter int TICK_CNT   = mswc_pkg::TICK_CYCLES,
	parameter int DETECT_CNT = mswc_pkg::DETECT_CYCLES
) (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// Wishbone slave
	input  wire mswc_pkg::mswc_wb_req_s wb_req_i,
	output mswc_pkg::mswc_wb_rsp_s      wb_rsp_o,
	// Modem activity
	input  wire logic                   sleep_req_i,
	input  wire logic                   tx_pending_i,
	input  wire logic                   tx_active_i,
	input  wire logic                   rx_active_i,
	input  wire logic                   serial_sleep_i,
	input  wire logic                   initializer_i,
	// Power state
	output logic                        asleep_o,
	output logic                        rx_enable_o,
	output logic [7:0]                  initializer_length_o,
	output logic [15:0]                 initializer_holdoff_o
);
	import mswc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic is_cyclic(input logic [3:0] s);
		is_cyclic = (s >= SLEEP_CYC_FIRST) && (s <= SLEEP_CYC_LAST);
	endfunction

	// Period in 100 ms ticks: 5 << (setting - 3)
	function automatic logic [7:0] period_ticks(input logic [3:0] s);
		logic [3:0] sh;
		sh = s - SLEEP_CYC_FIRST;
		period_ticks = 8'h05 << sh[2:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [3:0]  sleep_setting;
	logic        pin_wake_enable;
	logic [15:0] inactivity_timeout;
	logic [7:0]  initializer_length;
	logic [15:0] initializer_holdoff;
	mswc_state_e state;
	logic [15:0] idle_cnt;
	logic [7:0]  period_cnt;
	logic [31:0] tick_cnt;
	logic [31:0] det_cnt;
	logic        ack;
	logic [31:0] rdata;

	wire         wb_hit      = wb_req_i.cyc && wb_req_i.stb && !ack;
	wire         wb_wr       = wb_hit && wb_req_i.we;
	wire         wr_ctrl     = wb_wr && (wb_req_i.adr == REG_SLEEP_CTRL) && wb_req_i.sel[0];
	wire         wr_tmo      = wb_wr && (wb_req_i.adr == REG_TIMEOUT);
	wire         wr_init     = wb_wr && (wb_req_i.adr == REG_INIT_CFG);
	wire [15:0]  tmo_wdata   = {wb_req_i.sel[1] ? wb_req_i.dat[15:8] : inactivity_timeout[15:8],
	                            wb_req_i.sel[0] ? wb_req_i.dat[7:0] : inactivity_timeout[7:0]};
	// Out-of-range timeout writes are dropped so the value never goes below minimum
	wire         tmo_ok      = tmo_wdata >= TIMEOUT_MIN;
	wire [3:0]   wr_setting  = wb_req_i.dat[SLEEP_LSB +: 4];
	// Settings above 8 are refused; the old setting stays
	wire         setting_ok  = wr_setting <= SLEEP_CYC_LAST;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sleep_setting   <= SLEEP_RESET;
			pin_wake_enable <= PWAKE_RESET;
		end else if (wr_ctrl) begin
			if (setting_ok) begin
				sleep_setting <= wr_setting;
			end
			pin_wake_enable <= wb_req_i.dat[PWAKE_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inactivity_timeout <= TIMEOUT_RESET;
		end else if (wr_tmo && tmo_ok) begin
			inactivity_timeout <= tmo_wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			initializer_length  <= INIT_LEN_RESET;
			initializer_holdoff <= HOLDOFF_RESET;
		end else if (wr_init) begin
			if (wb_req_i.sel[0])
				initializer_length <= wb_req_i.dat[ILEN_LSB +: 8];
			if (wb_req_i.sel[2])
				initializer_holdoff[7:0] <= wb_req_i.dat[HOLD_LSB +: 8];
			if (wb_req_i.sel[3])
				initializer_holdoff[15:8] <= wb_req_i.dat[HOLD_LSB + 8 +: 8];
		end
	end

	// Unmapped reads return zero so software can probe the map safely
	function automatic logic [31:0] read_word(
		input logic [7:0]  adr,
		input logic [31:0] ctrl,
		input logic [31:0] tmo,
		input logic [31:0] init,
		input logic [31:0] stat
	);
		case (adr)
			REG_SLEEP_CTRL: read_word = ctrl;
			REG_TIMEOUT:    read_word = tmo;
			REG_INIT_CFG:   read_word = init;
			REG_STATUS:     read_word = stat;
			default:        read_word = 32'h00000000;
		endcase
	endfunction

	wire [31:0] ctrl_word   = {27'h0000000, pin_wake_enable, sleep_setting};
	wire [31:0] tmo_word    = {16'h0000, inactivity_timeout};
	wire [31:0] init_word   = {initializer_holdoff, 8'h00, initializer_length};
	wire [31:0] status_word = {24'h000000, 2'h0, rx_enable_o, asleep_o, 2'h0, state};
	wire [31:0] next_rdata  = read_word(wb_req_i.adr, ctrl_word, tmo_word, init_word, status_word);

	// One-cycle ack for every address; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack   <= 1'b0;
			rdata <= 32'h00000000;
		end else begin
			ack   <= wb_hit;
			rdata <= next_rdata;
		end
	end

	assign wb_rsp_o.ack = ack;
	assign wb_rsp_o.dat = rdata;

	////////////////////////////////////////////////////////////////////////////
	// 100 ms tick

	wire tick = (tick_cnt == 32'(TICK_CNT - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			tick_cnt <= 32'h00000000;
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sleep control

	wire cyclic      = is_cyclic(sleep_setting);
	wire pin_wake    = cyclic && pin_wake_enable;
	wire pin_hold    = pin_wake && !sleep_req_i;
	wire busy        = tx_active_i || rx_active_i || tx_pending_i;
	wire use_timer   = cyclic || (sleep_setting == SLEEP_SERIAL);
	wire idle_done   = idle_cnt >= inactivity_timeout;
	wire det_done    = det_cnt == 32'(DETECT_CNT - 1);
	wire period_done = period_cnt >= period_ticks(sleep_setting);
	wire pin_asleep  = (sleep_setting == SLEEP_PIN) && sleep_req_i;
	wire ser_asleep  = (sleep_setting == SLEEP_SERIAL) && serial_sleep_i;

	// Named state decodes keep the counter clears readable
	wire in_active   = (state == MSWC_ACTIVE);
	wire in_asleep   = (state == MSWC_ASLEEP);
	wire in_listen   = (state == MSWC_LISTEN);

	// Idle counter restarts on any activity, including pin release
	always_ff @(posedge clk_i) begin
		if (rst_i || busy || pin_hold || !in_active || !use_timer) begin
			idle_cnt <= 16'h0000;
		end else if (tick && !idle_done) begin
			idle_cnt <= idle_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !in_asleep) begin
			period_cnt <= 8'h00;
		end else if (tick) begin
			period_cnt <= period_cnt + 8'h01;
		end
	end

	// Initializer must be seen continuously for the detect time
	always_ff @(posedge clk_i) begin
		if (rst_i || !initializer_i || !in_listen) begin
			det_cnt <= 32'h00000000;
		end else if (!det_done) begin
			det_cnt <= det_cnt + 32'h00000001;
		end
	end

	mswc_state_e next_state;

	always_comb begin
		next_state = state;
		unique case (state)
			MSWC_ACTIVE: begin
				if (use_timer && idle_done && !busy && !pin_hold) begin
					next_state = MSWC_ASLEEP;
				end
			end
			MSWC_ASLEEP: begin
				if (!cyclic) begin
					next_state = MSWC_ACTIVE;
				end else if (pin_hold) begin
					next_state = MSWC_ACTIVE;
				end else if (period_done) begin
					next_state = MSWC_LISTEN;
				end
			end
			MSWC_LISTEN: begin
				if (!cyclic || pin_hold || tx_pending_i) begin
					next_state = MSWC_ACTIVE;
				end else if (det_done) begin
					next_state = MSWC_SYNC;
				end else if (tick && !initializer_i) begin
					next_state = MSWC_ASLEEP;
				end
			end
			MSWC_SYNC: begin
				if (!initializer_i) begin
					next_state = MSWC_ACTIVE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= MSWC_ACTIVE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			asleep_o    <= 1'b0;
			rx_enable_o <= 1'b1;
		end else begin
			asleep_o    <= (next_state == MSWC_ASLEEP) || pin_asleep || ser_asleep;
			rx_enable_o <= (next_state == MSWC_ACTIVE) && !pin_asleep && !ser_asleep;
		end
	end

	// Host must keep these consistent with the cyclic period
	assign initializer_length_o  = initializer_length;
	assign initializer_holdoff_o = initializer_holdoff;

endmodule // mswc_top

// ### bench/mswc_host_model.sv
`timescale 1ns/100ps
module mswc_host_model (
	// Clock
	input  wire logic clk_i,
	// Host intent
	input  wire logic want_sleep_i,
	input  wire logic slow_i,
	// Sleep request pin
	output logic      sleep_req_o
);
	// Slow mode lags the pin three cycles, as a sluggish host would
	logic [2:0] lag = 3'h7;
	initial sleep_req_o = 1'b1;
	always_ff @(posedge clk_i) begin
		lag <= {lag[1:0], want_sleep_i};
		sleep_req_o <= slow_i ? lag[2] : want_sleep_i;
	end
endmodule // mswc_host_model

// ### bench/mswc_top_sva.sv
`timescale 1ns/100ps
module mswc_top_sva import mswc_pkg::*; #(parameter int TICK_CNT = 10) (
	// Clock and reset
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	// Watched ports
	input wire mswc_pkg::mswc_wb_req_s wb_req_i,
	input wire mswc_pkg::mswc_wb_rsp_s wb_rsp_o,
	input wire logic                   sleep_req_i,
	input wire logic                   serial_sleep_i,
	input wire logic                   asleep_o,
	input wire logic                   rx_enable_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of the setting, tracked from acknowledged writes
	logic [3:0] set_q;
	logic       pw_q;
	int         slp_n;
	wire        wr_ctl  = wb_rsp_o.ack && wb_req_i.we && wb_req_i.adr == REG_SLEEP_CTRL && wb_req_i.sel[0];
	wire        cyc_set = set_q >= SLEEP_CYC_FIRST && set_q <= SLEEP_CYC_LAST;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			set_q <= SLEEP_RESET;
			pw_q <= PWAKE_RESET;
		end else if (wr_ctl) begin
			set_q <= (wb_req_i.dat[3:0] <= SLEEP_CYC_LAST) ? wb_req_i.dat[3:0] : set_q;
			pw_q <= wb_req_i.dat[PWAKE_BIT];
		end
	end
	always_ff @(posedge clk_i) begin
		slp_n <= asleep_o ? slp_n + 1 : 0;
	end
	sequence s_take;
		wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
	endsequence
	a_ack_answer: assert property (s_take |=> wb_rsp_o.ack) else $error("request not answered");
	a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb)) else $error("ack unasked");
	a_reset_out: assert property (disable iff (1'b0) rst_i |=> !asleep_o && rx_enable_o && !wb_rsp_o.ack)
		else $error("outputs wrong after reset");
	a_none_awake: assert property ((set_q == SLEEP_NONE)[*4] |-> !asleep_o) else $error("slept with no sleep");
	a_pin_awake: assert property ((cyc_set && pw_q && !sleep_req_i)[*4] |-> !asleep_o)
		else $error("slept with pin low");
	a_pin_sleep: assert property ((set_q == SLEEP_PIN && sleep_req_i)[*4] |-> asleep_o)
		else $error("pin sleep not taken");
	a_serial_awake: assert property ((set_q == SLEEP_SERIAL && !serial_sleep_i)[*4] |-> !asleep_o)
		else $error("serial sleep without cause");
	a_period_len: assert property ($fell(asleep_o) && set_q == SLEEP_CYC_FIRST && !pw_q |->
		slp_n >= 4 * TICK_CNT && slp_n <= 5 * TICK_CNT + 2) else $error("cyclic period wrong");
endmodule // mswc_top_sva
bind mswc_top mswc_top_sva #(.TICK_CNT(TICK_CNT)) i_mswc_top_sva (.clk_i(clk_i), .rst_i(rst_i),
	.wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .sleep_req_i(sleep_req_i), .serial_sleep_i(serial_sleep_i),
	.asleep_o(asleep_o), .rx_enable_o(rx_enable_o));

// ### bench/mswc_top_tb.sv
`timescale 1ns/100ps
module mswc_top_tb;
	import mswc_pkg::*;
	logic         clk_i = 0, rst_i = 1, tx_act = 0, ser = 0, init = 0, want = 1, slow = 0, sleep_req;
	mswc_wb_req_s req = '0;
	mswc_wb_rsp_s rsp;
	logic [31:0]  rq, t, expq[$];
	logic [7:0]   ilen;
	logic [15:0]  ihold;
	int           miscompares = 0, compares = 0, cyc_n = 0, seed = 80525;
	always #5 clk_i = ~clk_i;
	mswc_host_model i_mswc_host_model (.clk_i(clk_i), .want_sleep_i(want), .slow_i(slow), .sleep_req_o(sleep_req));
	// Short tick keeps the sleep periods within a short run
	mswc_top #(.TICK_CNT(10), .DETECT_CNT(4)) i_mswc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
		.wb_rsp_o(rsp), .sleep_req_i(sleep_req), .tx_pending_i(1'b0), .tx_active_i(tx_act), .rx_active_i(1'b0),
		.serial_sleep_i(ser), .initializer_i(init), .asleep_o(), .rx_enable_o(), .initializer_length_o(ilen),
		.initializer_holdoff_o(ihold));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b1, we, a, 4'hF, d};
		// Only the bench timeout ends a wait for the answer
		do @(posedge clk_i); while (rsp.ack !== 1'b1);
		rq = rsp.dat;
		req.cyc <= 1'b0;
		req.stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, '0);
	endtask
	// A short state such as listen would pass before a queued read lands
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		int k = 0;
		do bus(1'b0, REG_STATUS, '0); while ((rq & m) !== v && ++k < 90);
		check(rq & m, v);
	endtask
	always @(posedge clk_i) begin
		if (rsp.ack === 1'b1 && !req.we && expq.size() > 0) check(rsp.dat, expq.pop_front());
		if (++cyc_n > 40000) begin
			miscompares++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(REG_SLEEP_CTRL, 32'h0);
		rd(REG_TIMEOUT, 32'h64);
		rd(REG_INIT_CFG, {HOLDOFF_RESET, 8'h00, INIT_LEN_RESET});
		check({24'h000000, ilen}, {24'h000000, INIT_LEN_RESET});
		rd(REG_STATUS, 32'h20);
		bus(1'b1, REG_INIT_CFG, 32'hA5C30007);
		rd(REG_INIT_CFG, 32'hA5C30007);
		check({16'h0000, ihold}, 32'h0000A5C3);
		bus(1'b1, 8'h10, 32'hFFFF);
		rd(8'h10, 32'h0);
		t = 32'h10 + ($random(seed) & 32'h3FFF);
		bus(1'b1, REG_TIMEOUT, t);
		bus(1'b1, REG_TIMEOUT, 32'h0F);
		rd(REG_TIMEOUT, t);
		bus(1'b1, REG_TIMEOUT, 32'h10);
		bus(1'b1, REG_SLEEP_CTRL, 32'h1);
		poll(32'h10, 32'h10);
		want <= 1'b0;
		poll(32'h10, 32'h0);
		bus(1'b1, REG_SLEEP_CTRL, 32'h2);
		rd(REG_STATUS, 32'h20);
		ser <= 1'b1;
		poll(32'h10, 32'h10);
		ser <= 1'b0;
		bus(1'b1, REG_SLEEP_CTRL, 32'h9);
		rd(REG_SLEEP_CTRL, 32'h2);
		bus(1'b1, REG_SLEEP_CTRL, 32'h10);
		want <= 1'b1;
		repeat (250) @(posedge clk_i);
		rd(REG_STATUS, 32'h20);
		tx_act <= 1'b1;
		bus(1'b1, REG_SLEEP_CTRL, 32'h3);
		repeat (300) @(posedge clk_i);
		rd(REG_STATUS, 32'h20);
		tx_act <= 1'b0;
		repeat (140) @(posedge clk_i);
		rd(REG_STATUS, 32'h20);
		poll(32'h3F, 32'h11);
		poll(32'h3F, 32'h02);
		poll(32'h3F, 32'h11);
		init <= 1'b1;
		poll(32'h03, 32'h03);
		init <= 1'b0;
		poll(32'h3F, 32'h20);
		slow <= 1'b1;
		want <= 1'b0;
		bus(1'b1, REG_SLEEP_CTRL, 32'h13);
		repeat (300) @(posedge clk_i);
		rd(REG_STATUS, 32'h20);
		want <= 1'b1;
		poll(32'h3F, 32'h11);
		want <= 1'b0;
		poll(32'h3F, 32'h20);
		conclude();
	end
endmodule // mswc_top_tb
